//--- shared/pwr_seq_defines.svh
// register map, field values, defaults and timing for power-up sequencing
//
// Contract
// - ramp output over programmed rise time
// - time attempt, fault if undervoltage persists
// - zero limit disables the timeout
// - response 00 ignores the fault
// - response 01 operates for delay, then retries
// - response 10 disables then follows retries
// - response 11 disables until fault cleared
// - clear events release the latched fault
// - retry code 000 never restarts
// - codes 001-011 allow one to three restarts
// - restart spacing is decoded count times unit
// - wait turn-on delay before the ramp
// - delay count decodes as power of two
// - codes 100-110 four-six, 111 unlimited
// - delay unit shared with output voltage faults
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH

// -----------------------------------------------------------------------
// command codes
// -----------------------------------------------------------------------
`define CMD_RISE_TIME      8'h61
`define CMD_TIME_LIMIT     8'h62
`define CMD_TIMEOUT_RESP   8'h63

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define RST_RISE_TIME      16'h000a
`define RST_TIME_LIMIT     16'h0032
`define RST_TIMEOUT_RESP   8'hb8

// -----------------------------------------------------------------------
// response codes and retry field values
// -----------------------------------------------------------------------
`define RESP_IGNORE        2'h0
`define RESP_RUN_DELAY     2'h1
`define RESP_DISABLE_RETRY 2'h2
`define RESP_DISABLE_HOLD  2'h3
`define RETRY_NONE         3'h0
`define RETRY_FOREVER      3'h7

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define MS_NS              1000000
`define MS_CYCLES          (`MS_NS / `CLK_PERIOD_NS)

`endif

//--- shared/pwr_seq_pkg.sv
// types shared by the power-up sequencer
package pwr_seq_pkg;

    // timeout response byte as laid out in the register
    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retries;
        logic [2:0] dly_cnt;
    } resp_cfg_t;

    // sequencer states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_DELAY = 7'h02,
        ST_RISE  = 7'h04,
        ST_ON    = 7'h08,
        ST_HOLD  = 7'h10,
        ST_WAIT  = 7'h20,
        ST_LATCH = 7'h40
    } seq_state_t;

endpackage

//--- logic/power_up_timeout_fault_response.sv
// power-up sequencer with timeout fault response and retry handling
`timescale 1ns/1ps
`include "pwr_seq_defines.svh"

module power_up_timeout_fault_response #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    nrst_in,
    // command port
    input  wire logic                    reg_wr_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [15:0]             reg_wdata_in,
    output logic      [15:0]             reg_rdata_out,
    input  wire logic                    clear_faults_in,
    input  wire logic                    status_clear_in,
    // settings held elsewhere
    input  wire logic [15:0]             turn_on_delay_setting_in,
    input  wire logic [15:0]             vout_delay_unit_ms_in,
    // enable pin and power stage report
    input  wire logic                    enable_pin_in,
    input  wire logic                    uv_ok_pin_in,
    // sequencer outputs
    output logic                         output_en_out,
    output logic                         ramp_active_out,
    output logic                         timeout_fault_out,
    output logic      [2:0]              attempt_cnt_out,
    output pwr_seq_pkg::seq_state_t      state_out
);
    import pwr_seq_pkg::*;

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic [15:0]  rise_time_setting_r;
    logic [15:0]  power_up_time_limit_r;
    resp_cfg_t    timeout_response_setting_r;
    logic [1:0]   sync1_r;
    logic [1:0]   sync2_r;
    logic [1:0]   sync3_r;
    logic         en_q_r;
    logic         uv_q_r;
    logic [16:0]  pre_r;
    logic         ms_tick;
    logic         state_chg;
    logic [23:0]  tmr_r;
    seq_state_t   state_r;
    logic [2:0]   attempts_r;
    logic         to_seen_r;
    logic         fault_r;
    logic         en_fall;
    logic         fault_clr;
    logic         timeout_hit;
    logic         retry_ok;
    logic [23:0]  delay_ms;
    logic [23:0]  rise_ms;
    logic [23:0]  limit_ms;
    logic [23:0]  turn_on_delay_setting_ms;
    logic [1:0]   pins;

    // linear format time to whole milliseconds; negative mantissa means 0
    function automatic logic [23:0] lin_ms(input logic [15:0] v);
        logic [4:0]  e;
        logic [23:0] m;
        e = v[15:11];
        m = {13'h0, v[10:0]};
        if (v[10]) begin
            lin_ms = 24'h0;
        end else if (e[4]) begin
            lin_ms = m >> 5'(~e + 5'h1);
        end else begin
            lin_ms = m << e[3:0];
        end
    endfunction

    // -------------------------------------------------------------------
    // settings registers
    // -------------------------------------------------------------------
    // writes to unknown codes are dropped
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            rise_time_setting_r        <= `RST_RISE_TIME;
            power_up_time_limit_r      <= `RST_TIME_LIMIT;
            timeout_response_setting_r <= `RST_TIMEOUT_RESP;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `CMD_RISE_TIME:    rise_time_setting_r <= reg_wdata_in;
                `CMD_TIME_LIMIT:   power_up_time_limit_r <= reg_wdata_in;
                `CMD_TIMEOUT_RESP: timeout_response_setting_r <= reg_wdata_in[7:0];
                default: ;
            endcase
        end
    end

    // read data follows the address one cycle later; unmapped reads zero
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 16'h0;
        end else begin
            unique case (reg_addr_in)
                `CMD_RISE_TIME:    reg_rdata_out <= rise_time_setting_r;
                `CMD_TIME_LIMIT:   reg_rdata_out <= power_up_time_limit_r;
                `CMD_TIMEOUT_RESP: reg_rdata_out <= {8'h0, timeout_response_setting_r};
                default:           reg_rdata_out <= 16'h0;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    assign pins = {uv_ok_pin_in, enable_pin_in};

    // three stages; a level is taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge core_clk_in) begin
                if (!nrst_in) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= pins[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    // filtered levels
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            en_q_r <= 1'b0;
            uv_q_r <= 1'b0;
        end else begin
            if (sync2_r[0] == sync3_r[0]) en_q_r <= sync3_r[0];
            if (sync2_r[1] == sync3_r[1]) uv_q_r <= sync3_r[1];
        end
    end

    // enable dropping counts as commanded off
    assign en_fall = en_q_r && (sync2_r[0] == sync3_r[0]) && !sync3_r[0];

    // -------------------------------------------------------------------
    // millisecond timebase
    // -------------------------------------------------------------------
    // one tick per millisecond; restarts on every state change so that
    // each phase lasts at least its programmed time, never a fraction less
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pre_r <= 17'h0;
        end else if (ms_tick || state_chg) begin
            pre_r <= 17'h0;
        end else begin
            pre_r <= pre_r + 17'h1;
        end
    end
    assign state_chg = (state_r != state_out);
    assign ms_tick   = (pre_r == 17'(MS_CYCLES - 1)) && !state_chg;

    // -------------------------------------------------------------------
    // decoded times
    // -------------------------------------------------------------------
    assign rise_ms      = lin_ms(rise_time_setting_r);
    assign limit_ms     = lin_ms(power_up_time_limit_r);
    assign turn_on_delay_setting_ms = lin_ms(turn_on_delay_setting_in);
    assign delay_ms = {8'h0, vout_delay_unit_ms_in} << timeout_response_setting_r.dly_cnt;

    assign timeout_hit = (state_r == ST_RISE) && (limit_ms != 24'h0) && !to_seen_r
                         && (tmr_r >= limit_ms) && !uv_q_r;

    assign retry_ok = (timeout_response_setting_r.retries == `RETRY_FOREVER)
                      || (attempts_r < timeout_response_setting_r.retries);

    // any clear event releases the fault
    assign fault_clr = status_clear_in || clear_faults_in || en_fall;

    // -------------------------------------------------------------------
    // fault status
    // -------------------------------------------------------------------
    // a new timeout in the clearing cycle wins over the clear
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            fault_r <= 1'b0;
        end else if (timeout_hit) begin
            fault_r <= 1'b1;
        end else if (fault_clr) begin
            fault_r <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    // output is driven on in rise, on and hold; off everywhere else
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_r    <= ST_IDLE;
            tmr_r      <= 24'h0;
            attempts_r <= 3'h0;
            to_seen_r  <= 1'b0;
        end else if (!en_q_r || en_fall) begin
            state_r    <= ST_IDLE;
            tmr_r      <= 24'h0;
            attempts_r <= 3'h0;
            to_seen_r  <= 1'b0;
        end else begin
            if (ms_tick) tmr_r <= tmr_r + 24'h1;
            unique case (state_r)
                ST_IDLE: begin
                    tmr_r <= 24'h0;
                    if (!fault_r) state_r <= ST_DELAY;
                end
                ST_DELAY: begin
                    if (tmr_r >= turn_on_delay_setting_ms) begin
                        state_r   <= ST_RISE;
                        tmr_r     <= 24'h0;
                        to_seen_r <= 1'b0;
                    end
                end
                ST_RISE: begin
                    if (timeout_hit) begin
                        to_seen_r <= 1'b1;
                        tmr_r     <= 24'h0;
                        unique case (timeout_response_setting_r.resp)
                            `RESP_IGNORE: ;
                            `RESP_RUN_DELAY: state_r <= ST_HOLD;
                            `RESP_DISABLE_RETRY: begin
                                state_r    <= retry_ok ? ST_WAIT : ST_LATCH;
                                attempts_r <= retry_ok ? attempts_r + 3'h1 : attempts_r;
                            end
                            `RESP_DISABLE_HOLD: state_r <= ST_LATCH;
                        endcase
                    end else if (uv_q_r && tmr_r >= rise_ms) begin
                        state_r    <= ST_ON;
                        attempts_r <= 3'h0;
                    end
                end
                ST_ON: ;
                ST_HOLD: begin
                    // at the end, on if the output came good, else retry or latch
                    if (tmr_r >= delay_ms) begin
                        tmr_r <= 24'h0;
                        if (uv_q_r) begin
                            state_r    <= ST_ON;
                            attempts_r <= 3'h0;
                        end else begin
                            state_r    <= retry_ok ? ST_WAIT : ST_LATCH;
                            attempts_r <= retry_ok ? attempts_r + 3'h1 : attempts_r;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tmr_r >= delay_ms) begin
                        state_r   <= ST_RISE;
                        tmr_r     <= 24'h0;
                        to_seen_r <= 1'b0;
                    end
                end
                ST_LATCH: begin
                    if (fault_clr) begin
                        state_r    <= ST_IDLE;
                        attempts_r <= 3'h0;
                    end
                end
            endcase
            // unlimited retries must not wrap the counter
            if (attempts_r == 3'h7) attempts_r <= 3'h7;
        end
    end

    // -------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------
    // outputs lag the state by one cycle so they come from flops
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            output_en_out     <= 1'b0;
            ramp_active_out   <= 1'b0;
            timeout_fault_out <= 1'b0;
            attempt_cnt_out   <= 3'h0;
            state_out         <= ST_IDLE;
        end else begin
            output_en_out     <= (state_r == ST_RISE) || (state_r == ST_ON)
                                 || (state_r == ST_HOLD);
            // ramp runs for the rise time
            ramp_active_out   <= (state_r == ST_RISE) && (tmr_r < rise_ms);
            timeout_fault_out <= fault_r;
            attempt_cnt_out   <= attempts_r;
            state_out         <= state_r;
        end
    end

endmodule // power_up_timeout_fault_response

//--- sim/pwr_seq_monitor.sv
// assertion checker for the power-up sequencer ports
`timescale 1ns/1ps
module pwr_seq_monitor
    import pwr_seq_pkg::*;
(
    // clock and reset
    input wire logic                 core_clk_in,
    input wire logic                 nrst_in,
    // watched ports
    input wire logic                 enable_pin_in,
    input wire logic                 clear_faults_in,
    input wire logic                 status_clear_in,
    input wire logic                 output_en_out,
    input wire logic                 timeout_fault_out,
    input wire logic [2:0]           attempt_cnt_out,
    input wire pwr_seq_pkg::seq_state_t state_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    // two edges in one state, so the registered enable has caught up
    sequence s_held(seq_state_t st);
        state_out == st && $past(state_out) == st;
    endsequence

    // a clear request that arrives while the fault is latched
    sequence s_clear_latched;
        (clear_faults_in || status_clear_in) && state_out == ST_LATCH;
    endsequence

    chk_ramp_output_on: assert property (s_held(ST_RISE) |-> output_en_out)
        else $error("output off during ramp");
    chk_delay_output_off: assert property (s_held(ST_DELAY) |-> !output_en_out)
        else $error("output on during turn-on delay");
    chk_hold_output_on: assert property (s_held(ST_HOLD) |-> output_en_out)
        else $error("output off while operating through delay");
    chk_wait_output_off: assert property (s_held(ST_WAIT) |-> !output_en_out)
        else $error("output on while waiting to restart");
    chk_latch_output_off: assert property (s_held(ST_LATCH) |-> !output_en_out)
        else $error("output on while latched off");
    chk_latch_fault_held: assert property (s_held(ST_LATCH) |-> timeout_fault_out)
        else $error("fault flag low while latched off");
    chk_clear_releases: assert property (s_clear_latched |-> ##[1:2]
        (!timeout_fault_out && state_out == ST_IDLE))
        else $error("clear did not release the latched fault");
    chk_enable_off_resets: assert property ($fell(enable_pin_in) |-> ##[1:8]
        (state_out == ST_IDLE && !timeout_fault_out && attempt_cnt_out == 3'h0))
        else $error("enable low did not return to idle");
endmodule // pwr_seq_monitor

bind power_up_timeout_fault_response pwr_seq_monitor pwr_seq_monitor_i (
    .core_clk_in, .nrst_in, .enable_pin_in, .clear_faults_in, .status_clear_in,
    .output_en_out, .timeout_fault_out, .attempt_cnt_out, .state_out);

//--- sim/power_stage_model.sv
// behavioural power stage that reports when the output passes the undervoltage limit
`timescale 1ns/1ps
module power_stage_model #(
    parameter int RAMP_CYC = 30
) (
    // clock
    input  wire logic clk_in,
    // stage control
    input  wire logic output_en_in,
    input  wire logic stall_in,
    // level report
    output logic      uv_ok_out
);
    int cnt_r;

    // a stalled stage never reaches the limit, which is how a timeout is forced
    always_ff @(posedge clk_in) begin
        if (!output_en_in || stall_in) begin
            cnt_r <= 0;
        end else if (cnt_r < RAMP_CYC) begin
            cnt_r <= cnt_r + 1;
        end
    end

    assign uv_ok_out = (cnt_r == RAMP_CYC);
endmodule // power_stage_model

//--- sim/tb_top.sv
// self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module tb_top;
    import pwr_seq_pkg::*;
    localparam int MS = 10;  // cycles per ms, shortened so the run stays brief
    logic        core_clk_in, nrst_in, reg_wr_in, clear_faults_in, status_clear_in, stall;
    logic        enable_pin_in, uv_ok_pin_in, output_en_out, ramp_active_out, timeout_fault_out;
    logic [7:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, turn_on_delay_setting_in, vout_delay_unit_ms_in;
    logic [2:0]  attempt_cnt_out, dly;
    seq_state_t  state_out;
    int          error_cnt = 0, compares = 0, t, g;

    power_up_timeout_fault_response #(.MS_CYCLES(MS)) power_up_timeout_fault_response_i (
        .core_clk_in, .nrst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .clear_faults_in, .status_clear_in, .turn_on_delay_setting_in, .vout_delay_unit_ms_in,
        .enable_pin_in, .uv_ok_pin_in, .output_en_out, .ramp_active_out, .timeout_fault_out,
        .attempt_cnt_out, .state_out);
    power_stage_model power_stage_model_i (.clk_in(core_clk_in), .output_en_in(output_en_out),
        .stall_in(stall), .uv_ok_out(uv_ok_pin_in));

    // free-running clock
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        cyc(1);
        reg_wr_in = 1'b0;
        // let an edge pass so a following write never re-raises the strobe at once
        cyc(1);
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        reg_addr_in = a;
        cyc(1);
        check("read data", exp, reg_rdata_out);
    endtask
    task automatic wait_st(seq_state_t s, int lim);
        for (t = 0; state_out !== s && t < lim; t++) cyc(1);
        check("state", {9'h0, s}, {9'h0, state_out});
    endtask
    task automatic wait_en(logic v, int lim);
        for (t = 0; output_en_out !== v && t < lim; t++) cyc(1);
    endtask
    // dropping enable is one of the clear events, so each run starts clean
    task automatic go(logic [7:0] cfg);
        enable_pin_in = 1'b0;
        cyc(8);
        check("fault", 16'h0, {15'h0, timeout_fault_out});
        check("attempts", 16'h0, {13'h0, attempt_cnt_out});
        wr(8'h63, {8'h00, cfg});
        enable_pin_in = 1'b1;
    endtask
    // linear format: signed exponent over signed mantissa, negative time is zero
    function automatic int cyc_of(logic [15:0] v);
        int e = int'($signed(v[15:11]));
        int m = int'($signed(v[10:0]));
        if (m < 0) return 0;
        return (e < 0 ? m >>> -e : m <<< e) * MS;
    endfunction
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        #500000;
        error_cnt++;
        results();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        t = $urandom(32'h839f);
        {reg_wr_in, clear_faults_in, status_clear_in, enable_pin_in, stall} = '0;
        {nrst_in, reg_addr_in, reg_wdata_in} = '0;
        turn_on_delay_setting_in = 16'h0003;
        vout_delay_unit_ms_in = 16'h0001;
        cyc(2);
        nrst_in = 1'b1;
        rd(8'h61, 16'h000a);
        rd(8'h62, 16'h0032);
        rd(8'h63, 16'h00b8);
        rd(8'h64, 16'h0000);
        g = $urandom;
        wr(8'h61, g[15:0]);
        rd(8'h61, g[15:0]);
        wr(8'h63, g[31:16]);
        rd(8'h63, {8'h0, g[23:16]});
        wr(8'h61, 16'h000a);
        wr(8'h62, 16'h0004);
        // clean start: delay, ramp, then on
        go(8'hc0);
        wait_en(1'b1, 200);
        g = cyc_of(16'h0003);
        check("delay ok", 16'h1, 16'(t >= g && t <= g + 8));
        check("ramp", 16'h1, {15'h0, ramp_active_out});
        wait_st(ST_ON, 200);
        g = cyc_of(16'h000a);
        check("rise ok", 16'h1, 16'(t >= g - 2 && t <= g + 4));
        check("ramp", 16'h0, {15'h0, ramp_active_out});
        // stalled stage: ignore keeps running but flags
        stall = 1'b1;
        go(8'h00);
        wait_en(1'b1, 200);
        for (t = 0; timeout_fault_out !== 1'b1 && t < 200; t++) cyc(1);
        g = cyc_of(16'h0004);
        check("limit ok", 16'h1, 16'(t >= g - 2 && t <= g + 3));
        cyc(100);
        check("output en", 16'h1, {15'h0, output_en_out});
        // operate two units, then no retry
        go(8'h41);
        wait_st(ST_HOLD, 200);
        wait_st(ST_LATCH, 40);
        check("hold ok", 16'h1, 16'(t >= 2 * MS - 2 && t <= 2 * MS + 3));
        status_clear_in = 1'b1;
        cyc(1);
        status_clear_in = 1'b0;
        cyc(2);
        check("fault", 16'h0, {15'h0, timeout_fault_out});
        // disable and retry one to six times, random spacing and delay unit
        for (int r = 1; r <= 6; r++) begin
            dly = 3'($urandom_range(0, 2));
            vout_delay_unit_ms_in = 16'($urandom_range(1, 2));
            g = int'(vout_delay_unit_ms_in) * (MS << dly);
            go({2'b10, 3'(r), dly});
            wait_st(ST_WAIT, 200);
            wait_en(1'b1, 400);
            check("gap ok", 16'h1, 16'(t >= g - 1 && t <= g + 3));
            wait_st(ST_LATCH, 2000);
            check("attempts", 16'(r), {13'h0, attempt_cnt_out});
        end
        vout_delay_unit_ms_in = 16'h0001;
        // disable until cleared
        go(8'hc0);
        wait_st(ST_LATCH, 200);
        check("attempts", 16'h0, {13'h0, attempt_cnt_out});
        clear_faults_in = 1'b1;
        cyc(1);
        clear_faults_in = 1'b0;
        cyc(2);
        check("fault", 16'h0, {15'h0, timeout_fault_out});
        // unlimited retries never latch and the count stops at seven
        go(8'hb8);
        cyc(600);
        check("unlimited", 16'h1, {15'h0, state_out !== ST_LATCH});
        check("attempts", 16'h7, {13'h0, attempt_cnt_out});
        // a successful retry resets the attempt count
        go(8'h98);
        wait_st(ST_WAIT, 200);
        stall = 1'b0;
        wait_st(ST_ON, 400);
        check("attempts", 16'h0, {13'h0, attempt_cnt_out});
        // zero limit never times out
        stall = 1'b1;
        wr(8'h62, 16'h0000);
        go(8'hc0);
        cyc(300);
        check("fault", 16'h0, {15'h0, timeout_fault_out});
        check("state", {9'h0, ST_RISE}, {9'h0, state_out});
        results();
    end
endmodule // tb_top
